// File: rtl/rtccs_pkg.sv
/*
  Shared constants for the real-time counter control and read-sync block:
  register indices, field positions, reset values and sync timing.
  Assumes a 32-bit APB with byte addresses equal to four times the index.
*/
package rtccs_pkg;

  // Register indices; byte address is four times the index
  localparam logic [5:0]  IDX_CTRL        = 6'h00;
  localparam logic [5:0]  IDX_READ_REQUEST_BIT        = 6'h02;
  localparam logic [5:0]  IDX_EVENT_OUTPUT_CONTROL      = 6'h04;
  localparam logic [5:0]  IDX_IRQ_FLAG    = 6'h08;
  localparam logic [5:0]  IDX_STATUS      = 6'h0A;
  localparam logic [5:0]  IDX_IRQ_MASK    = 6'h0E;

  // Control fields
  localparam int          CTRL_SOFT_RESET_TRIGGER_BIT  = 0;
  localparam int          CTRL_EN_BIT     = 1;
  localparam int          CTRL_MODE_LSB   = 2;
  localparam int          CTRL_HOUR_BIT   = 6;
  localparam int          CTRL_MCLR_BIT   = 7;
  localparam int          CTRL_PRESC_LSB  = 8;
  localparam logic [15:0] CTRL_RESET      = 16'h0000;

  // Read request fields
  localparam int          READ_REQUEST_BIT_REQ_BIT    = 15;
  localparam int          READ_REQUEST_BIT_CONT_BIT   = 14;
  localparam logic [5:0]  READ_REQUEST_BIT_ADDR_VALUE = 6'h10;
  localparam logic [15:0] READ_REQUEST_BIT_RESET      = 16'h0010;

  // Event control fields
  localparam int          EV_OVF_BIT      = 15;
  localparam int          EV_CMP0_BIT     = 8;
  localparam logic [15:0] EV_WRITE_MASK   = 16'h81FF;
  localparam logic [15:0] EV_RESET        = 16'h0000;

  // Status and interrupt fields
  localparam int          STATUS_BUSY_BIT = 7;
  localparam int          IRQ_SYNCRDY_BIT = 0;
  localparam int          IRQ_OVF_BIT     = 1;

  // Mode codes and prescaler limit
  localparam logic [1:0]  MODE_WIDE       = 2'h0;
  localparam logic [1:0]  MODE_NARROW     = 2'h1;
  localparam logic [1:0]  MODE_CALENDAR   = 2'h2;
  localparam logic [3:0]  PRESC_MAX       = 4'hA;

  // Source clock edges a handshake takes
  localparam logic [1:0]  SYNC_EDGES      = 2'h2;

  typedef enum logic [0:0] {
    SYNC_IDLE,
    SYNC_WAIT
  } rtccs_sync_t;

endpackage

// File: rtl/rtccs_edge_sync.sv
/*
  Two-flop synchroniser with rising edge detect for the source clock pin.
  Assumes the input is asynchronous to clk_in.
*/
`timescale 1ns/1ps
module rtccs_edge_sync (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rst_n_in,
  // Asynchronous level
  input  wire logic async_in,
  // Synchronised level and edge
  output logic      level_out,
  output logic      rise_out
);
  import rtccs_pkg::*;

  typedef struct packed {
    logic meta;
    logic sync;
    logic last;
  } rtccs_sync_state_t;

  rtccs_sync_state_t s_q;
  rtccs_sync_state_t s_d;

  // Edge detect reads only the second and third flops
  always_comb begin
    s_d      = s_q;
    s_d.meta = async_in;
    s_d.sync = s_q.meta;
    s_d.last = s_q.sync;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign level_out = s_q.sync;
  assign rise_out  = s_q.sync & ~s_q.last;

endmodule

// File: rtl/rtccs_top.sv
/*
  Control, read-request and event-enable registers of a real-time counter,
  with the enable/reset/read handshake towards the source clock pin.
  Assumes an APB master on SYS_CLK_IN and a counter datapath on the same clock.
*/
// Local design decision: the APB slave port.
// Overview of operation
// - Divider code n divides source clock by two to the n, codes up to 0xA.
// - Mode field picks wide counter, narrow counter or calendar; code 3 reserved.
// - Enable reads back at once; a change sets busy and takes effect when handshake ends.
// - Enable and soft reset bits are writable even while the block runs.
// - Soft reset one resets all registers and disables; zero does nothing.
// - A write carrying soft reset discards every other field of that write.
// - Soft reset reads one while pending; it and busy clear together.
// - Clear-on-match clears counter on match in every mode except narrow, reserved code 3 included.
// - Clear-on-match and hour format change only while the block is disabled.
// - Hour format bit picks 24-hour or 12-hour clock representation.
// - Divider, mode, clear-on-match and hour format writes need no handshake.
// - Writing read request one starts a read sync and sets busy.
// - Continuous read re-syncs the counter each time it updates.
// - Continuous read keeps the read request from clearing itself.
// - Continuous read clears when software writes the counter value register.
// - Read-sync address field is read-only and always reads 0x10.
// - Overflow event output only when the overflow event enable is set.
// - Registers accept 8-, 16- and 32-bit accesses through byte strobes.
`timescale 1ns/1ps
module rtccs_top (
  // Clock and reset
  input  wire logic        SYS_CLK_IN,
  input  wire logic        RESET_N_IN,
  // APB slave
  input  wire logic        PSEL_IN,
  input  wire logic        PENABLE_IN,
  input  wire logic        PWRITE_IN,
  input  wire logic [7:0]  PADDR_IN,
  input  wire logic [31:0] PWDATA_IN,
  input  wire logic [3:0]  PSTRB_IN,
  output logic      [31:0] PRDATA_OUT,
  output logic             PREADY_OUT,
  output logic             PSLVERR_OUT,
  // Source timing clock pin
  input  wire logic        SOURCE_TIMING_CLOCK_IN,
  // Counter datapath status
  input  wire logic        COUNT_OVERFLOW_IN,
  input  wire logic        COUNT_MATCH_IN,
  input  wire logic        COUNT_UPDATE_IN,
  input  wire logic        COUNT_WRITE_IN,
  // Counter datapath control
  output logic             COUNTER_TICK_CLOCK_OUT,
  output logic             BLOCK_ENABLED_OUT,
  output logic      [1:0]  OPERATING_MODE_OUT,
  output logic             HOUR_FORMAT_SELECT_OUT,
  output logic             COUNTER_CLEAR_OUT,
  output logic             READ_SYNC_LOAD_OUT,
  // Events and interrupt
  output logic             OVERFLOW_EVENT_OUT,
  output logic             COMPARE0_EVENT_OUT,
  output logic      [7:0]  PERIODIC_EVENT_ENABLE_OUT,
  output logic             IRQ_OUT
);
  import rtccs_pkg::*;

  typedef struct packed {
    logic [3:0]  presc;
    logic        mclr;
    logic        hour;
    logic [1:0]  mode;
    logic        ctrl_en;
    logic        soft_reset_trigger;
    logic        read_request_bit;
    logic        continuous_read_bit;
    logic [15:0] ev;
    logic [1:0]  irq;
    logic [1:0]  mask;
    logic        en_active;
    logic        pend;
    rtccs_sync_t sync;
    logic [1:0]  edge_cnt;
    logic [9:0]  presc_cnt;
    logic        tick;
    logic        ovf_ev;
    logic        cmp_ev;
    logic        clr;
    logic        rsync;
    logic [31:0] prdata;
    logic        slverr;
  } rtccs_state_t;

  rtccs_state_t s_q;
  rtccs_state_t s_d;

  logic src_rise;
  logic wr_acc;
  logic rd_setup;
  logic sync_done;
  logic busy;
  logic guarded;

  // Address match on an aligned word
  function automatic logic hit(input logic [7:0] addr, input logic [5:0] idx);
    hit = (addr[7:2] == idx) && (addr[1:0] == 2'b00);
  endfunction

  // Byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                          input logic [15:0] new_v,
                                          input logic [3:0]  strb);
    merge16[7:0]  = strb[0] ? new_v[7:0]  : old_v[7:0];
    merge16[15:8] = strb[1] ? new_v[15:8] : old_v[15:8];
  endfunction

  // Low bits that must all be one for a tick
  function automatic logic [9:0] div_mask(input logic [3:0] code);
    logic [3:0]  c;
    logic [10:0] t;
    c        = (code > PRESC_MAX) ? PRESC_MAX : code;
    t        = (11'h001 << c) - 11'h001;
    div_mask = t[9:0];
  endfunction

  function automatic logic [15:0] ctrl_word(input rtccs_state_t s);
    ctrl_word                              = 16'h0000;
    ctrl_word[CTRL_PRESC_LSB +: 4]         = s.presc;
    ctrl_word[CTRL_MCLR_BIT]               = s.mclr;
    ctrl_word[CTRL_HOUR_BIT]               = s.hour;
    ctrl_word[CTRL_MODE_LSB +: 2]          = s.mode;
    ctrl_word[CTRL_EN_BIT]                 = s.ctrl_en;
    ctrl_word[CTRL_SOFT_RESET_TRIGGER_BIT]              = s.soft_reset_trigger;
  endfunction

  rtccs_edge_sync u_src_sync (
    .clk_in    (SYS_CLK_IN),
    .rst_n_in  (RESET_N_IN),
    .async_in  (SOURCE_TIMING_CLOCK_IN),
    .level_out (),
    .rise_out  (src_rise)
  );

  assign wr_acc    = PSEL_IN & PENABLE_IN & PWRITE_IN;
  assign rd_setup  = PSEL_IN & ~PENABLE_IN & ~PWRITE_IN;
  assign busy      = s_q.pend | (s_q.sync == SYNC_WAIT);
  assign guarded   = s_q.ctrl_en | s_q.en_active;
  assign sync_done = (s_q.sync == SYNC_WAIT) && src_rise &&
                     (s_q.edge_cnt == SYNC_EDGES - 2'h1);

  always_comb begin
    logic [15:0] rd16;
    logic [15:0] nv;
    rd16     = 16'h0000;
    nv       = 16'h0000;
    s_d      = s_q;
    s_d.tick   = 1'b0;
    s_d.rsync  = 1'b0;

    // Read data is captured in the setup phase
    if (rd_setup) begin
      s_d.slverr = 1'b0;
      if (hit(PADDR_IN, IDX_CTRL)) begin
        rd16 = ctrl_word(s_q);
      end else if (hit(PADDR_IN, IDX_READ_REQUEST_BIT)) begin
        rd16[READ_REQUEST_BIT_CONT_BIT] = s_q.continuous_read_bit;
        rd16[5:0]           = READ_REQUEST_BIT_ADDR_VALUE;
      end else if (hit(PADDR_IN, IDX_EVENT_OUTPUT_CONTROL)) begin
        rd16 = s_q.ev;
      end else if (hit(PADDR_IN, IDX_IRQ_FLAG)) begin
        rd16[1:0] = s_q.irq;
      end else if (hit(PADDR_IN, IDX_STATUS)) begin
        rd16[STATUS_BUSY_BIT] = busy;
      end else if (hit(PADDR_IN, IDX_IRQ_MASK)) begin
        rd16[1:0] = s_q.mask;
      end else begin
        s_d.slverr = 1'b1;
      end
      s_d.prdata = {16'h0000, rd16};
    end

    // Read clears only the flags it returned
    if (PSEL_IN && PENABLE_IN && !PWRITE_IN && hit(PADDR_IN, IDX_IRQ_FLAG)) begin
      s_d.irq = s_q.irq & ~s_q.prdata[1:0];
    end

    // Writes are dropped while a soft reset is pending
    if (wr_acc && !s_q.soft_reset_trigger) begin
      if (hit(PADDR_IN, IDX_CTRL)) begin
        nv = merge16(ctrl_word(s_q), PWDATA_IN[15:0], PSTRB_IN);
        if (PSTRB_IN[0] && PWDATA_IN[CTRL_SOFT_RESET_TRIGGER_BIT]) begin
          s_d.soft_reset_trigger = 1'b1;
          s_d.pend  = 1'b1;
        end else begin
          if (PSTRB_IN[0]) begin
            s_d.ctrl_en = nv[CTRL_EN_BIT];
          end
          // Only a change of enable syncs; mode, hour and clear-on-match share its byte lane
          if (PSTRB_IN[0] && (nv[CTRL_EN_BIT] != s_q.ctrl_en)) begin
            s_d.pend    = 1'b1;
          end
          if (!guarded) begin
            s_d.presc = nv[CTRL_PRESC_LSB +: 4];
            s_d.mode  = nv[CTRL_MODE_LSB +: 2];
            s_d.mclr  = nv[CTRL_MCLR_BIT];
            s_d.hour  = nv[CTRL_HOUR_BIT];
          end
        end
      end
      if (hit(PADDR_IN, IDX_READ_REQUEST_BIT) && PSTRB_IN[1]) begin
        if (PWDATA_IN[READ_REQUEST_BIT_REQ_BIT]) begin
          s_d.read_request_bit = 1'b1;
          s_d.pend = 1'b1;
        end
        s_d.continuous_read_bit = PWDATA_IN[READ_REQUEST_BIT_CONT_BIT];
      end
      if (hit(PADDR_IN, IDX_EVENT_OUTPUT_CONTROL) && !guarded) begin
        s_d.ev = merge16(s_q.ev, PWDATA_IN[15:0], PSTRB_IN) & EV_WRITE_MASK;
      end
      if (hit(PADDR_IN, IDX_IRQ_MASK) && PSTRB_IN[0]) begin
        s_d.mask = PWDATA_IN[1:0];
      end
    end

    // Counter value written by software ends continuous reads
    if (COUNT_WRITE_IN) begin
      s_d.continuous_read_bit = 1'b0;
    end

    // Each counter update re-arms a read sync
    if (COUNT_UPDATE_IN && s_q.continuous_read_bit && s_q.read_request_bit) begin
      s_d.pend = 1'b1;
    end

    // Handshake towards the source clock
    case (s_q.sync)
      SYNC_IDLE: begin
        if (s_q.pend) begin
          s_d.pend     = 1'b0;
          s_d.sync     = SYNC_WAIT;
          s_d.edge_cnt = 2'h0;
        end
      end
      SYNC_WAIT: begin
        if (src_rise) begin
          s_d.edge_cnt = s_q.edge_cnt + 2'h1;
        end
        if (sync_done) begin
          s_d.sync      = SYNC_IDLE;
          s_d.en_active = s_q.ctrl_en;
          s_d.irq[IRQ_SYNCRDY_BIT] = 1'b1;
          if (s_q.read_request_bit) begin
            s_d.rsync = 1'b1;
            s_d.read_request_bit  = s_q.continuous_read_bit;
          end
        end
      end
      default: begin
        s_d.sync = SYNC_IDLE;
      end
    endcase

    // Divided tick from source edges
    if (s_q.en_active && src_rise) begin
      s_d.presc_cnt = s_q.presc_cnt + 10'h001;
      s_d.tick      = (s_q.presc_cnt & div_mask(s_q.presc)) == div_mask(s_q.presc);
    end
    if (!s_q.en_active) begin
      s_d.presc_cnt = 10'h000;
    end

    // Event and clear outputs, one cycle behind their cause
    s_d.ovf_ev = COUNT_OVERFLOW_IN & s_q.ev[EV_OVF_BIT] & s_q.en_active;
    s_d.cmp_ev = COUNT_MATCH_IN & s_q.ev[EV_CMP0_BIT] & s_q.en_active;
    s_d.clr    = COUNT_MATCH_IN & s_q.mclr & s_q.en_active &
                 (s_q.mode != MODE_NARROW);
    if (COUNT_OVERFLOW_IN && s_q.en_active) begin
      s_d.irq[IRQ_OVF_BIT] = 1'b1;
    end

    // Completed soft reset returns everything except read data and slave error to reset values
    if (sync_done && s_q.soft_reset_trigger) begin
      s_d        = '0;
      s_d.prdata = s_q.prdata;
      s_d.slverr = s_q.slverr;
    end
  end

  always_ff @(posedge SYS_CLK_IN or negedge RESET_N_IN) begin
    if (!RESET_N_IN) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign PRDATA_OUT                = s_q.prdata;
  assign PREADY_OUT                = 1'b1;
  assign PSLVERR_OUT               = PSEL_IN & PENABLE_IN & s_q.slverr;
  assign COUNTER_TICK_CLOCK_OUT    = s_q.tick;
  assign BLOCK_ENABLED_OUT         = s_q.en_active;
  assign OPERATING_MODE_OUT        = s_q.mode;
  assign HOUR_FORMAT_SELECT_OUT    = s_q.hour;
  assign COUNTER_CLEAR_OUT         = s_q.clr;
  assign READ_SYNC_LOAD_OUT        = s_q.rsync;
  assign OVERFLOW_EVENT_OUT        = s_q.ovf_ev;
  assign COMPARE0_EVENT_OUT        = s_q.cmp_ev;
  assign PERIODIC_EVENT_ENABLE_OUT = s_q.ev[7:0];
  assign IRQ_OUT                   = |(s_q.irq & s_q.mask);

  default clocking cb @(posedge SYS_CLK_IN);
  endclocking
  default disable iff (!RESET_N_IN);

  a_enable_readback: assert property (wr_acc && hit(PADDR_IN, IDX_CTRL) && PSTRB_IN[0]
      && !PWDATA_IN[0] && !s_q.soft_reset_trigger && (PWDATA_IN[1] != s_q.ctrl_en)
      |=> s_q.ctrl_en == $past(PWDATA_IN[1]) && busy)
    else $error("enable write not read back with busy");
  a_soft_reset_trigger_discard: assert property (wr_acc && hit(PADDR_IN, IDX_CTRL) && PSTRB_IN[0]
      && PWDATA_IN[0] && !s_q.soft_reset_trigger |=> s_q.soft_reset_trigger && $stable(s_q.mode) && $stable(s_q.ctrl_en))
    else $error("soft reset write did not discard fields");
  a_soft_reset_trigger_release: assert property ($fell(s_q.soft_reset_trigger) |-> !busy && !s_q.en_active
      && s_q.ev == EV_RESET)
    else $error("soft reset ended with state left");
  a_hour_guard: assert property (wr_acc && hit(PADDR_IN, IDX_CTRL) && guarded
      && PSTRB_IN[0] && !PWDATA_IN[0] && !s_q.soft_reset_trigger |=> $stable(s_q.hour) && $stable(s_q.mclr))
    else $error("protected field changed while enabled");
  a_no_handshake: assert property (wr_acc && hit(PADDR_IN, IDX_CTRL) && PSTRB_IN == 4'b0010
      && !busy |=> !busy)
    else $error("divider write started a handshake");
  a_read_request: assert property (wr_acc && hit(PADDR_IN, IDX_READ_REQUEST_BIT) && PSTRB_IN[1]
      && PWDATA_IN[15] && !s_q.soft_reset_trigger |=> busy ##[1:40] s_q.rsync || s_q.soft_reset_trigger)
    else $error("read request gave no sync");
  a_continuous_read_bit_holds: assert property (sync_done && s_q.continuous_read_bit && s_q.read_request_bit && !s_q.soft_reset_trigger
      |=> s_q.read_request_bit)
    else $error("read request cleared in continuous mode");
  a_continuous_read_bit_clear: assert property (COUNT_WRITE_IN |=> !s_q.continuous_read_bit)
    else $error("continuous read survived value write");
  a_addr_const: assert property (rd_setup && hit(PADDR_IN, IDX_READ_REQUEST_BIT)
      |=> s_q.prdata[5:0] == READ_REQUEST_BIT_ADDR_VALUE)
    else $error("read-sync address not constant");
  a_overflow_event: assert property (COUNT_OVERFLOW_IN && s_q.en_active
      |=> OVERFLOW_EVENT_OUT == $past(s_q.ev[EV_OVF_BIT]))
    else $error("overflow event not gated by enable");
  a_narrow_noclear: assert property (s_q.mode == MODE_NARROW |=> !COUNTER_CLEAR_OUT)
    else $error("clear on match in narrow mode");
  a_div1_tick: assert property (s_q.en_active && s_q.presc == 4'h0 && src_rise
      |=> COUNTER_TICK_CLOCK_OUT)
    else $error("divide by one missed a tick");

endmodule

// File: verif/rtccs_top_tb.sv
/*
  Self-checking bench for the real-time counter control and read-sync block:
  APB register tasks, handshake waits, event pulses and interrupt checks.
  Assumes the design answers APB with zero wait states and a free source clock.
*/
`timescale 1ns/1ps
module rtccs_top_tb;
  import rtccs_pkg::*;
  logic        clk, rst_n, psel, penable, pwrite, src_clk;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic        pready, pslverr, err, ovf, match, upd, cwr;
  logic        tick, enabled, hour, cclr, load, ovf_ev, cmp_ev, irq;
  logic [1:0]  mode;
  logic [7:0]  per_en;
  int          n_mismatch, comparisons, n_tick, n_load, l0;

  rtccs_top u_dut (
    .SYS_CLK_IN(clk), .RESET_N_IN(rst_n), .PSEL_IN(psel), .PENABLE_IN(penable),
    .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PSTRB_IN(pstrb),
    .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
    .SOURCE_TIMING_CLOCK_IN(src_clk), .COUNT_OVERFLOW_IN(ovf), .COUNT_MATCH_IN(match),
    .COUNT_UPDATE_IN(upd), .COUNT_WRITE_IN(cwr), .COUNTER_TICK_CLOCK_OUT(tick),
    .BLOCK_ENABLED_OUT(enabled), .OPERATING_MODE_OUT(mode),
    .HOUR_FORMAT_SELECT_OUT(hour), .COUNTER_CLEAR_OUT(cclr),
    .READ_SYNC_LOAD_OUT(load), .OVERFLOW_EVENT_OUT(ovf_ev),
    .COMPARE0_EVENT_OUT(cmp_ev), .PERIODIC_EVENT_ENABLE_OUT(per_en), .IRQ_OUT(irq)
  );

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  // Unrelated phase to the bus clock on purpose
  initial begin
    src_clk = 1'b0;
    #7;
    forever #200 src_clk = ~src_clk;
  end

  always @(posedge clk) begin
    if (tick === 1'b1) n_tick++;
    if (load === 1'b1) n_load++;
  end

  task automatic report_and_stop();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] s);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    pstrb   <= s;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd  = prdata;
    err = pslverr;
    if (n >= 50) check("pready", 32'h0000_0001, {31'h0, pready});
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 4'hF);
  endtask

  task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000, 4'h0);
    check(name, exp, rd);
  endtask

  // Polls status busy; bounded so a stuck handshake shows up
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      apb(1'b0, 8'h28, 32'h0000_0000, 4'h0);
      n++;
    end while (rd[STATUS_BUSY_BIT] !== 1'b0 && n < 100);
    check("busy_end", 32'h0000_0000, {31'h0, rd[STATUS_BUSY_BIT]});
  endtask

  task automatic pulse(input logic [3:0] v);
    @(posedge clk);
    {ovf, match, upd, cwr} <= v;
    @(posedge clk);
    {ovf, match, upd, cwr} <= 4'h0;
    #1;
  endtask

  initial begin
    repeat (40000) @(posedge clk);
    n_mismatch++;
    report_and_stop();
  end

  initial begin
    {rst_n, psel, penable, pwrite, ovf, match, upd, cwr} = 8'h00;
    paddr  = 8'h00;
    pwdata = 32'h0000_0000;
    pstrb  = 4'h0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    rdchk("ctrl_rst", 8'h00, 32'h0000_0000);
    rdchk("read_request_bit_rst", 8'h08, 32'h0000_0010);
    rdchk("event_output_control_rst", 8'h10, 32'h0000_0000);
    wr(8'h00, 32'h0000_03C8);
    apb(1'b1, 8'h00, 32'h0000_0505, 4'h2);
    rdchk("ctrl_fields", 8'h00, 32'h0000_05C8);
    rdchk("busy_unsynced", 8'h28, 32'h0000_0000);
    check("mode", 32'h0000_0002, {30'h0, mode});
    check("hour", 32'h0000_0001, {31'h0, hour});
    wr(8'h10, 32'h0000_FFFF);
    rdchk("event_output_control", 8'h10, 32'h0000_81FF);
    check("per_en", 32'h0000_00FF, {24'h0, per_en});
    wr(8'h00, 32'h0000_05CA);
    rdchk("ctrl_en", 8'h00, 32'h0000_05CA);
    apb(1'b0, 8'h28, 32'h0000_0000, 4'h0);
    check("busy_set", 32'h0000_0001, {31'h0, rd[STATUS_BUSY_BIT]});
    check("en_early", 32'h0000_0000, {31'h0, enabled});
    wait_idle();
    check("en_done", 32'h0000_0001, {31'h0, enabled});
    check("irq_masked", 32'h0000_0000, {31'h0, irq});
    wr(8'h00, 32'h0000_0002);
    rdchk("ctrl_prot", 8'h00, 32'h0000_05CA);
    // Divider 5: one tick per 32 source rises, 256 bus cycles
    n_tick = 0;
    repeat (1280) @(posedge clk);
    check("tick_ok", 32'h0000_0001, {31'h0, n_tick >= 4 && n_tick <= 6});
    pulse(4'b1100);
    check("ovf_ev", 32'h0000_0001, {31'h0, ovf_ev});
    check("cmp_ev", 32'h0000_0001, {31'h0, cmp_ev});
    check("cclr", 32'h0000_0001, {31'h0, cclr});
    wr(8'h38, 32'h0000_0003);
    #1;
    check("irq_on", 32'h0000_0001, {31'h0, irq});
    apb(1'b0, 8'h20, 32'h0000_0000, 4'h0);
    check("flag_rdy", 32'h0000_0001, {31'h0, rd[0]});
    @(posedge clk);
    #1;
    check("irq_off", 32'h0000_0000, {31'h0, irq});
    n_load = 0;
    wr(8'h08, 32'h0000_8000);
    wait_idle();
    check("load_once", 32'h0000_0001, n_load);
    rdchk("read_request_bit_wo", 8'h08, 32'h0000_0010);
    wr(8'h08, 32'h0000_C000);
    rdchk("continuous_read_bit", 8'h08, 32'h0000_4010);
    wait_idle();
    l0 = n_load;
    pulse(4'b0010);
    repeat (4) @(posedge clk);
    wait_idle();
    check("resync", 32'h0000_0001, {31'h0, n_load > l0});
    pulse(4'b0001);
    rdchk("continuous_read_bit_clr", 8'h08, 32'h0000_0010);
    wait_idle();
    wr(8'h00, 32'h0000_05C8);
    wait_idle();
    check("en_off", 32'h0000_0000, {31'h0, enabled});
    wr(8'h00, 32'h0000_0F0F);
    rdchk("soft_reset_trigger_on", 8'h00, 32'h0000_05C9);
    wait_idle();
    rdchk("ctrl_clr", 8'h00, 32'h0000_0000);
    rdchk("ev_clr", 8'h10, 32'h0000_0000);
    rdchk("mask_clr", 8'h38, 32'h0000_0000);
    wr(8'h00, 32'h0000_0002);
    wait_idle();
    pulse(4'b1000);
    check("ovf_gated", 32'h0000_0000, {31'h0, ovf_ev});
    apb(1'b0, 8'h3C, 32'h0000_0000, 4'h0);
    check("unmapped_err", 32'h0000_0001, {31'h0, err});
    check("unmapped_rd", 32'h0000_0000, rd);
    report_and_stop();
  end
endmodule
